// [core/modem_status_scanner.sv]
// Notes on behaviour
// - Control/status word selects line and mode; line register passes selected line's status.
// - While scan-enable, step over enabled lines comparing status to stored copy.
// - On change: stop, record change in 15..12, keep line, set done, interrupt.
// - Bits 3..0 are a read/write line number, 0 to 15.
// - Line number cleared by reset or scan-clear.
// - Line number is presettable counter; written, or advanced by scan or step.
// - Busy reads one while scanning or a scan-clear runs.
// - Scanning starts only while done is zero; found change sets done.
// - Scanning halts within 1.2 us after scan-enable clears; busy held till then.
// - Scan-enable cleared by reset and scan-clear.
// - Interrupt-enable gates done onto the interrupt; cleared by reset and scan-clear.
// - On done the selected line's current status shows in the line register.
// - Scan-clear clears fields and wipes scan memory within 18.8 us.
// - Step increments line, sets done on change; done does not block it.
`timescale 1ns/1ps
`default_nettype none
`include "modem_scan_defines.svh"

module modem_status_scanner
  import modem_scan_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host access to the control/status word
  input wire csr_req_s csrReq,
  output logic [15:0] csrRdata,
  // Per-line modem status and line-on bits from the line register
  input wire logic [15:0][3:0] modemStatus,
  input wire logic [15:0] lineOn,
  // Selected line towards the line register
  output logic [3:0] selLine,
  output logic [3:0] selStatus,
  // Interrupt request at priority four
  output logic irq
);

  localparam logic [15:0] DWELL = 16'(`DWELL_CYC);
  localparam logic [15:0] CLEARC = 16'(`CLEAR_CYC);
  // Scan halts one cycle after scan-enable drops, far inside the stop budget

  scan_reg_s q, d;
  logic [3:0] scanMem [16];
  logic memWr;
  logic [3:0] memIdx;
  logic [3:0] memVal;

  // Transition on a line relative to the stored copy
  function automatic logic [3:0] changed(input logic [3:0] cur, input logic [3:0] old);
    changed = cur ^ old;
  endfunction

  logic [3:0] curSt;
  logic [3:0] diff;
  logic wrNow;
  // High in the cycle a scan or step records a change
  logic doneSet;
  assign curSt = modemStatus[q.line];
  assign diff = changed(curSt, scanMem[q.line]);
  assign wrNow = csrReq.wr;

  // Next state
  always_comb begin
    d = q;
    memWr = 1'b0;
    memIdx = q.line;
    memVal = curSt;
    doneSet = 1'b0;
    d.dwell = (q.dwell == 16'h0) ? 16'h0 : q.dwell - 16'h1;
    unique case (q.state)
      ST_IDLE: begin
        if (q.scanEn && !q.done) begin
          d.state = ST_SCAN;
          d.dwell = DWELL;
        end
      end
      ST_SCAN: begin
        if (!q.scanEn) begin
          d.state = ST_IDLE;
        end else if (q.dwell == 16'h0) begin
          if (lineOn[q.line] && diff != 4'h0) begin
            d.trans = diff;
            d.done = 1'b1;
            doneSet = 1'b1;
            d.state = ST_IDLE;
            memWr = 1'b1;
          end else begin
            d.line = q.line + 4'h1;
            d.dwell = DWELL;
            memWr = lineOn[q.line];
          end
        end
      end
      ST_CLEAR: begin
        memWr = 1'b1;
        memIdx = q.clrIdx;
        memVal = 4'h0;
        d.clrIdx = q.clrIdx + 4'h1;
        if (q.dwell == 16'h0) begin
          d.state = ST_IDLE;
        end
      end
      default: d.state = ST_IDLE;
    endcase
    // Single step, after the settling time of the new line
    if (q.stepPend && q.dwell == 16'h0 && q.state != ST_CLEAR) begin
      d.stepPend = 1'b0;
      if (lineOn[q.line] && diff != 4'h0) begin
        d.trans = diff;
        d.done = 1'b1;
        doneSet = 1'b1;
        memWr = 1'b1;
        memIdx = q.line;
        memVal = curSt;
      end
    end
    if (wrNow) begin
      d.line = csrReq.wdata[`CSR_LINE_HI:`CSR_LINE_LO];
      d.scanEn = csrReq.wdata[`CSR_SCANEN];
      d.intEn = csrReq.wdata[`CSR_INTEN];
      // A change found in the same cycle wins over the host's clear
      if (!csrReq.wdata[`CSR_DONE] && !doneSet) d.done = 1'b0;
      if (csrReq.wdata[`CSR_STEP]) begin
        d.line = q.line + 4'h1;
        d.stepPend = 1'b1;
        d.dwell = DWELL;
      end
      if (csrReq.wdata[`CSR_CLRSCAN]) begin
        d.line = `LINE_RST;
        d.scanEn = 1'b0;
        d.intEn = 1'b0;
        d.done = 1'b0;
        d.trans = `TRANS_RST;
        d.stepPend = 1'b0;
        d.clrIdx = 4'h0;
        d.dwell = CLEARC;
        d.state = ST_CLEAR;
      end
    end
    d.rdata = {d.trans, 1'b0, 2'b00, 1'b0, d.done, d.intEn, d.scanEn,
               (d.state != ST_IDLE), d.line};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{state: ST_IDLE, line: `LINE_RST, scanEn: 1'b0, intEn: 1'b0, done: 1'b0,
             trans: `TRANS_RST, dwell: 16'h0, clrIdx: 4'h0, rdata: 16'h0, stepPend: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Scan memory, no reset: wiped by scan-clear
  always_ff @(posedge clk_sys) begin
    if (memWr) scanMem[memIdx] <= memVal;
  end

  assign csrRdata = q.rdata;
  assign selLine = q.line;
  assign selStatus = curSt;
  assign irq = q.done && q.intEn;

  property p_halt;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.state == ST_SCAN && !q.scanEn) |=> (q.state != ST_SCAN);
  endproperty
  a_halt: assert property (p_halt) else $error("scan not halted");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n) (wrNow && !csrReq.wdata[`CSR_INTEN]) |=> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_clr;
    @(posedge clk_sys) disable iff (!rst_n)
      (wrNow && csrReq.wdata[`CSR_CLRSCAN]) |=> (q.line == 4'h0 && !q.scanEn && !q.intEn && !q.done
        && q.state == ST_CLEAR && q.dwell == CLEARC);
  endproperty
  a_clr: assert property (p_clr) else $error("scan-clear incomplete");

  property p_busy;
    @(posedge clk_sys) disable iff (!rst_n) csrRdata[`CSR_BUSY] == ($past(d.state) != ST_IDLE);
  endproperty
  a_busy: assert property (p_busy) else $error("busy wrong");

  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.state == ST_SCAN && q.scanEn && q.dwell == 16'h0 && q.line == 4'hf && !wrNow
       && !(lineOn[15] && diff != 4'h0)) |=> q.line == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  property p_start;
    @(posedge clk_sys) disable iff (!rst_n) (q.state == ST_IDLE && q.done) |=> q.state != ST_SCAN;
  endproperty
  a_start: assert property (p_start) else $error("scan started with done");

  // Dwell over on an enabled line that differs from memory
  sequence s_hit;
    q.state == ST_SCAN && q.scanEn && q.dwell == 16'h0 && lineOn[q.line] && diff != 4'h0 && !wrNow;
  endsequence

  property p_found;
    @(posedge clk_sys) disable iff (!rst_n)
      s_hit |=> (q.done && q.state == ST_IDLE && q.trans == $past(diff));
  endproperty
  a_found: assert property (p_found) else $error("change not recorded");

  property p_clrdone;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.state == ST_CLEAR && !wrNow) |=> (q.state != ST_CLEAR || q.dwell == $past(q.dwell) - 16'h1);
  endproperty
  // Entered at the full count and stepped down each cycle, so the clear ends in bounded time
  a_clrdone: assert property (p_clrdone) else $error("clear too long");

  property p_step;
    @(posedge clk_sys) disable iff (!rst_n)
      (wrNow && csrReq.wdata[`CSR_STEP] && !csrReq.wdata[`CSR_CLRSCAN]) |=> q.line == $past(q.line) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("step missed");

endmodule
`default_nettype wire

// [inc/modem_scan_defines.svh]
`ifndef MODEM_SCAN_DEFINES_SVH
`define MODEM_SCAN_DEFINES_SVH
// Control/status word field positions
`define CSR_LINE_LO 0
`define CSR_LINE_HI 3
`define CSR_BUSY 4
`define CSR_SCANEN 5
`define CSR_INTEN 6
`define CSR_DONE 7
`define CSR_STEP 8
`define CSR_CLRSCAN 11
`define CSR_TRANS_LO 12
`define CSR_TRANS_HI 15
// Reset values
`define LINE_RST 4'h0
`define TRANS_RST 4'h0
// Timing, in nanoseconds, and derived cycle counts at 4 ns
`define CLK_PERIOD_NS 4
`define DWELL_NS 75
`define DWELL_CYC ((`DWELL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STOP_NS 1200
`define STOP_CYC (`STOP_NS / `CLK_PERIOD_NS)
`define CLEAR_NS 18800
`define CLEAR_CYC (`CLEAR_NS / `CLK_PERIOD_NS)
`endif

// [inc/modem_scan_pkg.sv]
`default_nettype none
package modem_scan_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_CLEAR = 2'b10
  } scan_state_e;

  // Host access to the control/status word
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } csr_req_s;

  typedef struct packed {
    scan_state_e state;
    logic [3:0] line;
    logic scanEn;
    logic intEn;
    logic done;
    logic [3:0] trans;
    logic [15:0] dwell;
    logic [3:0] clrIdx;
    logic [15:0] rdata;
    logic stepPend;
  } scan_reg_s;
endpackage
`default_nettype wire

// [verif/modem_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module modem_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench commands
  input wire logic setStb,
  input wire logic [3:0] setIdx,
  input wire logic [3:0] setVal,
  // Levels towards the scanner
  output logic [15:0][3:0] modemStatus,
  output logic [15:0] lineOn
);
  // Levels hold between commands; a command also switches its line on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modemStatus <= '0;
      lineOn <= 16'h0000;
    end else if (setStb) begin
      modemStatus[setIdx] <= setVal;
      lineOn[setIdx] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [verif/tb_modem_status_scanner.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_modem_status_scanner import modem_scan_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_n;
  csr_req_s csrReq;
  logic [15:0] csrRdata;
  logic [15:0][3:0] modemStatus;
  logic [15:0] lineOn;
  logic [3:0] selLine;
  logic [3:0] selStatus;
  logic irq;
  logic setStb;
  logic [3:0] setIdx;
  logic [3:0] setVal;
  int bad_count;
  int tests_run;
  // 4 ns period
  always #2 clk_sys = ~clk_sys;
  modem_status_scanner uut (.clk_sys(clk_sys), .rst_n(rst_n), .csrReq(csrReq), .csrRdata(csrRdata),
    .modemStatus(modemStatus), .lineOn(lineOn), .selLine(selLine), .selStatus(selStatus), .irq(irq));
  modem_bank modems (.clk_sys(clk_sys), .rst_n(rst_n), .setStb(setStb), .setIdx(setIdx),
    .setVal(setVal), .modemStatus(modemStatus), .lineOn(lineOn));
  task automatic report_and_stop();
    $display("counts: tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Strobe for one edge, then leave one edge for the read word to settle
  task automatic csr_write(input logic [15:0] d);
    @(negedge clk_sys);
    csrReq.wr = 1'b1;
    csrReq.wdata = d;
    @(negedge clk_sys);
    csrReq.wr = 1'b0;
    @(negedge clk_sys);
  endtask
  // Bounded wait on one bit of the read word
  task automatic wait_bit(input int idx, input logic val, input int bound);
    int n;
    n = 0;
    while (csrRdata[idx] !== val) begin
      @(negedge clk_sys);
      n++;
      if (n > bound) begin
        check({15'h0000, csrRdata[idx]}, {15'h0000, val});
        report_and_stop();
      end
    end
  endtask
  task automatic set_modem(input logic [3:0] idx, input logic [3:0] val);
    @(negedge clk_sys);
    setStb = 1'b1;
    setIdx = idx;
    setVal = val;
    @(negedge clk_sys);
    setStb = 1'b0;
  endtask
  initial begin
    rst_n = 1'b0;
    csrReq = '0;
    setStb = 1'b0;
    setIdx = 4'h0;
    setVal = 4'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    check(csrRdata, 16'h0000);
    $display("test reset done");
    // Scan-clear wipes fields set just before; memory is unknown until then
    csr_write(16'h0047);
    check(csrRdata, 16'h0047);
    csr_write(16'h0800);
    check({15'h0000, csrRdata[4]}, 16'h0001);
    wait_bit(4, 1'b0, 4800);
    check(csrRdata, 16'h0000);
    $display("test scan clear done");
    // Step from 15 carries the same line field, so load order cannot matter
    csr_write(16'h000f);
    check(csrRdata, 16'h000f);
    csr_write(16'h010f);
    repeat (40) @(negedge clk_sys);
    check({12'h000, selLine}, 16'h0000);
    check(csrRdata, 16'h0000);
    $display("test step wrap done");
    // Only line 5 differs from scan memory
    for (int i = 0; i < 16; i++) begin
      set_modem(4'(i), (i == 5) ? 4'h9 : 4'h0);
    end
    csr_write(16'h0060);
    check({15'h0000, csrRdata[4]}, 16'h0001);
    wait_bit(7, 1'b1, 400);
    check(csrRdata, 16'h90e5);
    check({15'h0000, irq}, 16'h0001);
    check({12'h000, selStatus}, 16'h0009);
    csr_write(16'h0045);
    check({15'h0000, irq}, 16'h0000);
    $display("test scan find done");
    // Stop a running scan and wait for busy to fall; long enough to wrap past line 15
    csr_write(16'h0065);
    repeat (260) @(negedge clk_sys);
    check({15'h0000, csrRdata[4]}, 16'h0001);
    csr_write(16'h0045);
    wait_bit(4, 1'b0, 300);
    check(csrRdata & 16'h00ff, 16'h0045);
    $display("test scan stop done");
    // Step onto a changed line sets done; done does not block a further step
    set_modem(4'h6, 4'h3);
    csr_write(16'h0105);
    repeat (30) @(negedge clk_sys);
    check(csrRdata, 16'h3086);
    csr_write(16'h0186);
    check({12'h000, selLine}, 16'h0007);
    repeat (30) @(negedge clk_sys);
    check(csrRdata, 16'h3087);
    $display("test step find done");
    // Non-interrupt mode: fix one line, let it settle, poll its status
    csr_write(16'h0002);
    set_modem(4'h2, 4'ha);
    repeat (4000) @(negedge clk_sys);
    check({12'h000, selStatus}, 16'h000a);
    check(csrRdata, 16'h3002);
    $display("test polled line done");
    report_and_stop();
  end
endmodule
`default_nettype wire
